// ==== clock_pkg.sv ====
// Purpose: Shared constants, mode codes and helper functions for the panel clock.
// Assumes: 10 MHz reference clock on mclk_i.
// Notes:   Digits are BCD nibbles; DIGIT_BLANK turns a position dark.
package clock_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SECOND_NS       = 1_000_000_000;
    localparam int SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
    localparam int DEBOUNCE_NS     = 20_000_000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TEST_HOLD_S     = 2;
    localparam int TEST_CYCLES     = TEST_HOLD_S * SECOND_CYCLES;
    localparam int BLINK_PERIOD_S  = 2;
    localparam int BLINK_ON_NS     = 200_000_000;
    localparam int BLINK_CYCLES    = BLINK_ON_NS / CLK_PERIOD_NS;
    localparam int FT_SEC_PER_TENTH = 360;
    // ==========================================================
    // Counting limits and display codes
    localparam logic [4:0]  HOURS_PER_DAY = 5'd24;
    localparam logic [5:0]  MAX_MIN_SEC   = 6'h3b;
    localparam logic [6:0]  EL_MAX_HOURS  = 7'h63;
    localparam logic [23:0] FT_MAX        = 24'h999999;
    localparam logic [3:0]  DIGIT_BLANK   = 4'hf;
    localparam logic [23:0] ALL_BLANK     = 24'hffffff;
    localparam logic [23:0] ALL_EIGHT     = 24'h888888;
    // ==========================================================
    // Modes
    typedef enum logic [3:0] {
        M_LOCAL   = 4'h1,
        M_UTC     = 4'h2,
        M_FLIGHT  = 4'h4,
        M_ELAPSED = 4'h8
    } mode_e;

    function automatic mode_e mode_next(input mode_e m);
        case (m)
            M_LOCAL:  mode_next = M_UTC;
            M_UTC:    mode_next = M_FLIGHT;
            M_FLIGHT: mode_next = M_ELAPSED;
            default:  mode_next = M_LOCAL;
        endcase
    endfunction

    function automatic logic [7:0] to_bcd(input logic [6:0] v);
        to_bcd = {4'(v / 7'd10), 4'(v % 7'd10)};
    endfunction

    function automatic logic [23:0] disp_hms(input logic [6:0] h, input logic [5:0] m,
                                             input logic [5:0] s, input logic show);
        if (show) begin
            disp_hms = {to_bcd(h), to_bcd({1'b0, m}), to_bcd({1'b0, s})};
        end else begin
            disp_hms = {DIGIT_BLANK, DIGIT_BLANK, to_bcd(h), to_bcd({1'b0, m})};
        end
    endfunction

    // Six-digit BCD increment that sticks at the top value
    function automatic logic [23:0] bcd_inc(input logic [23:0] v);
        logic [23:0] r;
        logic        carry;
        r     = v;
        carry = 1'b1;
        if (v != FT_MAX) begin
            for (int i = 0; i < 6; i++) begin
                if (carry) begin
                    if (r[4*i +: 4] == 4'h9) begin
                        r[4*i +: 4] = 4'h0;
                    end else begin
                        r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                        carry       = 1'b0;
                    end
                end
            end
        end
        bcd_inc = r;
    endfunction
endpackage

// ==== input_filter.sv ====
// Purpose: Synchroniser and debouncer for one panel or discrete input.
// Assumes: Raw input is asynchronous to mclk_i.
// Notes:   Level changes only after DEB_CYCLES of agreement between stages two and three.
`timescale 1ns/1ps
module input_filter
    import clock_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES
) (
    input  wire logic mclk_i,   // Reference clock
    input  wire logic rst_n_i,  // Synchronous reset, active low
    input  wire logic raw_i,    // Raw asynchronous input
    output logic      level_o,  // Debounced level
    output logic      rise_o    // One-cycle pulse on debounced rise
);
    logic        s1;
    logic        s2;
    logic        s3;
    logic [17:0] cnt;

    // ==========================================================
    // Synchroniser
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= raw_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ==========================================================
    // Debounce: contact bounce restarts the count
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            cnt     <= 18'h0;
        end else begin
            rise_o <= 1'b0;
            if (s2 == s3 && s3 != level_o) begin
                if (cnt == 18'(DEB_CYCLES - 1)) begin
                    level_o <= s3;
                    rise_o  <= s3;
                    cnt     <= 18'h0;
                end else begin
                    cnt <= cnt + 18'h1;
                end
            end else begin
                cnt <= 18'h0;
            end
        end
    end
endmodule

// ==== cockpit_clock_chronometer.sv ====
// Purpose: Mode, timekeeping and display logic of a panel clock/chronometer.
// Assumes: Clock and this logic stay powered from the battery; main_power_i reports bus power.
// Notes:   Digits are BCD nibbles, most significant first; 4'hf is a dark digit.
`timescale 1ns/1ps
module cockpit_clock_chronometer
    import clock_pkg::*;
#(
    parameter int SEC_CYC   = SECOND_CYCLES,
    parameter int BLINK_CYC = BLINK_CYCLES,
    parameter int TEST_CYC  = TEST_CYCLES,
    parameter int DEB_CYC   = DEBOUNCE_CYCLES
) (
    input  wire logic        mclk_i,       // 10 MHz reference clock
    input  wire logic        rst_n_i,      // Synchronous reset, active low
    input  wire logic        main_power_i, // Main power present, pin level
    input  wire logic        mode_btn_i,   // MODE button, high when pressed
    input  wire logic        minus_btn_i,  // Minus button, high when pressed
    input  wire logic        plus_btn_i,   // Plus button, high when pressed
    input  wire logic        ft_enable_i,  // Flight timer enable discrete, high active
    input  wire logic        hour24_i,     // Local time in 24 hour format
    input  wire logic        show_sec_i,   // Show seconds
    input  wire logic        set_i,        // One-cycle strobe: load set values
    input  wire logic        set_utc_i,    // Strobe targets universal hours
    input  wire logic        set_mmss_i,   // Strobe also loads minutes and seconds
    input  wire logic [4:0]  set_hh_i,     // Hours to load, 0 to 23
    input  wire logic [5:0]  set_mm_i,     // Minutes to load, 0 to 59
    input  wire logic [5:0]  set_ss_i,     // Seconds to load, 0 to 59
    input  wire logic        ft_clear_i,   // One-cycle strobe: clear resettable timer
    output logic      [23:0] digits_o,     // Six BCD digits
    output logic             dp_o,         // Decimal point
    output logic             ann_utc_o,    // UTC annunciator
    output logic             ann_flight_o, // FLIGHT annunciator
    output logic             ann_timer_o   // TIMER annunciator
);
    logic        pwr;
    logic        pwr_rise;
    logic        mode_rise;
    logic        minus_lvl;
    logic        minus_rise;
    logic        plus_lvl;
    logic        plus_rise;
    logic        ft_lvl;
    mode_e       mode;
    logic [23:0] tick_cnt;
    logic        sec_tick;
    logic        even_sec;
    logic [24:0] hold_cnt;
    logic        test_on;
    logic [4:0]  loc_hh;
    logic [4:0]  utc_hh;
    logic [5:0]  mm;
    logic [5:0]  ss;
    logic [8:0]  ft_sec;
    logic [23:0] ft_res;
    logic [23:0] ft_tot;
    logic [6:0]  el_hh;
    logic [5:0]  el_mm;
    logic [5:0]  el_ss;
    logic        el_run;
    logic [4:0]  hh12;
    logic        blink;
    logic [23:0] next_digits;
    logic        next_dp;
    logic [2:0]  next_ann;

    // ==========================================================
    // Input conditioning
    input_filter #(.DEB_CYCLES(DEB_CYC)) u_pwr (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .raw_i(main_power_i), .level_o(pwr), .rise_o(pwr_rise));
    input_filter #(.DEB_CYCLES(DEB_CYC)) u_mode (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .raw_i(mode_btn_i), .level_o(), .rise_o(mode_rise));
    input_filter #(.DEB_CYCLES(DEB_CYC)) u_minus (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .raw_i(minus_btn_i), .level_o(minus_lvl), .rise_o(minus_rise));
    input_filter #(.DEB_CYCLES(DEB_CYC)) u_plus (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .raw_i(plus_btn_i), .level_o(plus_lvl), .rise_o(plus_rise));
    input_filter #(.DEB_CYCLES(DEB_CYC)) u_ften (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .raw_i(ft_enable_i), .level_o(ft_lvl), .rise_o());

    // ==========================================================
    // One second timebase; runs on battery so the clocks never stop
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tick_cnt <= 24'h0;
            sec_tick <= 1'b0;
            even_sec <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            if (tick_cnt == 24'(SEC_CYC - 1)) begin
                tick_cnt <= 24'h0;
                sec_tick <= 1'b1;
                even_sec <= ~even_sec;
            end else begin
                tick_cnt <= tick_cnt + 24'h1;
            end
        end
    end

    // ==========================================================
    // Mode selection
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mode <= M_LOCAL;
        end else if (pwr_rise) begin
            mode <= M_LOCAL;
        end else if (pwr && mode_rise && !test_on) begin
            mode <= mode_next(mode);
        end
    end

    property p_mode_step;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && mode_rise && !test_on && !pwr_rise) |=> (mode == mode_next($past(mode)));
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode did not advance");

    property p_power_local;
        @(posedge mclk_i) disable iff (!rst_n_i)
        pwr_rise |=> (mode == M_LOCAL) ##1 (!ann_utc_o && !ann_flight_o && !ann_timer_o);
    endproperty
    a_power_local: assert property (p_power_local) else $error("power-up not local");

    // ==========================================================
    // Display test hold timer
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hold_cnt <= 25'h0;
            test_on  <= 1'b0;
        end else if (pwr && minus_lvl && plus_lvl) begin
            if (hold_cnt == 25'(TEST_CYC - 1)) begin
                test_on <= 1'b1;
            end else begin
                hold_cnt <= hold_cnt + 25'h1;
            end
        end else begin
            hold_cnt <= 25'h0;
            test_on  <= 1'b0;
        end
    end

    // ==========================================================
    // Local and universal time; minutes and seconds are one shared pair
    // so setting them in either mode sets both, and they can never drift apart
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            loc_hh <= 5'h0;
            utc_hh <= 5'h0;
            mm     <= 6'h0;
            ss     <= 6'h0;
        end else if (pwr && set_i) begin
            if (set_utc_i) begin
                utc_hh <= set_hh_i;
            end else begin
                loc_hh <= set_hh_i;
            end
            if (set_mmss_i) begin
                mm <= set_mm_i;
                ss <= set_ss_i;
            end
        end else if (sec_tick) begin
            ss <= (ss == MAX_MIN_SEC) ? 6'h0 : ss + 6'h1;
            if (ss == MAX_MIN_SEC) begin
                mm <= (mm == MAX_MIN_SEC) ? 6'h0 : mm + 6'h1;
                if (mm == MAX_MIN_SEC) begin
                    loc_hh <= (loc_hh == HOURS_PER_DAY - 5'h1) ? 5'h0 : loc_hh + 5'h1;
                    utc_hh <= (utc_hh == HOURS_PER_DAY - 5'h1) ? 5'h0 : utc_hh + 5'h1;
                end
            end
        end
    end

    // ==========================================================
    // Flight timers, tenths of an hour
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ft_sec <= 9'h0;
            ft_res <= 24'h0;
            ft_tot <= 24'h0;
        end else begin
            if (pwr && ft_lvl && sec_tick) begin
                if (ft_sec == 9'(FT_SEC_PER_TENTH - 1)) begin
                    ft_sec <= 9'h0;
                    ft_tot <= bcd_inc(ft_tot);
                    ft_res <= bcd_inc(ft_res);
                end else begin
                    ft_sec <= ft_sec + 9'h1;
                end
            end
            if (pwr && ft_clear_i) begin
                ft_res <= 24'h0;
            end
        end
    end

    property p_ft_hold;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !pwr |=> (ft_res == $past(ft_res)) && (ft_tot == $past(ft_tot));
    endproperty
    a_ft_hold: assert property (p_ft_hold) else $error("flight timer moved without power");

    property p_ft_sat;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ft_tot == FT_MAX) |=> (ft_tot == FT_MAX);
    endproperty
    a_ft_sat: assert property (p_ft_sat) else $error("flight total passed its maximum");

    // ==========================================================
    // Elapsed timer; dropped on power loss since it is not battery kept
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !pwr) begin
            el_hh  <= 7'h0;
            el_mm  <= 6'h0;
            el_ss  <= 6'h0;
            el_run <= 1'b0;
        end else if (minus_rise && mode == M_ELAPSED) begin
            el_hh <= 7'h0;
            el_mm <= 6'h0;
            el_ss <= 6'h0;
        end else begin
            if (plus_rise && mode == M_ELAPSED) begin
                el_run <= ~el_run;
            end
            if (el_run && sec_tick) begin
                el_ss <= (el_ss == MAX_MIN_SEC) ? 6'h0 : el_ss + 6'h1;
                if (el_ss == MAX_MIN_SEC) begin
                    el_mm <= (el_mm == MAX_MIN_SEC) ? 6'h0 : el_mm + 6'h1;
                    if (el_mm == MAX_MIN_SEC) begin
                        el_hh <= (el_hh == EL_MAX_HOURS) ? 7'h0 : el_hh + 7'h1;
                    end
                end
            end
        end
    end

    property p_el_wrap;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && el_run && sec_tick && !minus_rise && el_hh == EL_MAX_HOURS
         && el_mm == MAX_MIN_SEC && el_ss == MAX_MIN_SEC)
        |=> (el_hh == 7'h0 && el_mm == 6'h0 && el_ss == 6'h0);
    endproperty
    a_el_wrap: assert property (p_el_wrap) else $error("elapsed timer did not wrap");

    property p_el_toggle;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && mode == M_ELAPSED && plus_rise && !minus_rise) |=> (el_run != $past(el_run));
    endproperty
    a_el_toggle: assert property (p_el_toggle) else $error("plus did not toggle timer");

    property p_el_clear;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && mode == M_ELAPSED && minus_rise) |=>
        (el_hh == 7'h0 && el_mm == 6'h0 && el_ss == 6'h0 && el_run == $past(el_run));
    endproperty
    a_el_clear: assert property (p_el_clear) else $error("minus did not clear timer");

    // ==========================================================
    // Display composition
    assign blink = pwr && ft_lvl && even_sec && (tick_cnt < 24'(BLINK_CYC));

    always_comb begin
        hh12        = (loc_hh >= 5'd12) ? loc_hh - 5'd12 : loc_hh;
        hh12        = (hh12 == 5'h0) ? 5'd12 : hh12;
        next_digits = ALL_BLANK;
        next_dp     = 1'b0;
        next_ann    = 3'h0;
        if (!pwr) begin
            next_digits = ALL_BLANK;
        end else if (test_on) begin
            next_digits = ALL_EIGHT;
            next_dp     = 1'b1;
            next_ann    = 3'h7;
        end else begin
            case (mode)
                M_LOCAL: begin
                    next_digits = disp_hms({2'b00, hour24_i ? loc_hh : hh12}, mm, ss,
                                           show_sec_i);
                end
                M_UTC: begin
                    next_digits = disp_hms({2'b00, utc_hh}, mm, ss, show_sec_i);
                    next_ann    = 3'h4;
                end
                M_FLIGHT: begin
                    next_digits = (minus_lvl || plus_lvl) ? ft_tot : ft_res;
                    next_dp     = blink;
                    next_ann    = 3'h2;
                end
                M_ELAPSED: begin
                    next_digits = disp_hms(el_hh, el_mm, el_ss, 1'b1);
                    next_ann    = 3'h1;
                end
                default: begin
                    next_digits = ALL_BLANK;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            digits_o     <= ALL_BLANK;
            dp_o         <= 1'b0;
            ann_utc_o    <= 1'b0;
            ann_flight_o <= 1'b0;
            ann_timer_o  <= 1'b0;
        end else begin
            digits_o     <= next_digits;
            dp_o         <= next_dp;
            ann_utc_o    <= next_ann[2];
            ann_flight_o <= next_ann[1];
            ann_timer_o  <= next_ann[0];
        end
    end

    property p_blank;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !pwr |=> (digits_o == ALL_BLANK) && !dp_o && !ann_utc_o && !ann_flight_o && !ann_timer_o;
    endproperty
    a_blank: assert property (p_blank) else $error("display lit without power");

    property p_utc_ann;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && !test_on && mode == M_UTC) |=> (ann_utc_o && !ann_flight_o && !ann_timer_o);
    endproperty
    a_utc_ann: assert property (p_utc_ann) else $error("UTC annunciator wrong");

    property p_ft_show;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && !test_on && mode == M_FLIGHT) |=>
        (digits_o == (($past(minus_lvl) || $past(plus_lvl)) ? $past(ft_tot) : $past(ft_res)))
        && ann_flight_o;
    endproperty
    a_ft_show: assert property (p_ft_show) else $error("wrong flight timer shown");

    property p_no_blink;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && !test_on && !ft_lvl) |=> !dp_o;
    endproperty
    a_no_blink: assert property (p_no_blink) else $error("point lit with timer idle");

    property p_test;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (pwr && test_on) |=> (digits_o == ALL_EIGHT) && dp_o && ann_utc_o && ann_flight_o
        && ann_timer_o;
    endproperty
    a_test: assert property (p_test) else $error("display test pattern wrong");
endmodule

// ==== panel_model.sv ====
// Purpose: Front-panel buttons and flight timer discrete seen from outside the clock.
// Assumes: Buttons are held long enough to pass the debouncer.
// Notes:   Levels change only just after a rising edge.
`timescale 1ns/1ps
module panel_model (
    input  wire logic mclk_i,      // Reference clock
    output logic      mode_btn_o,  // MODE button
    output logic      minus_btn_o, // Minus button
    output logic      plus_btn_o,  // Plus button
    output logic      ft_enable_o  // Flight timer enable discrete
);
    initial begin
        mode_btn_o  = 1'b0;
        minus_btn_o = 1'b0;
        plus_btn_o  = 1'b0;
        ft_enable_o = 1'b1;
    end
    // Press one button (0 mode, 1 minus, 2 plus), then release for a full debounce
    task automatic press(input int b);
        @(posedge mclk_i);
        if (b == 0) mode_btn_o <= 1'b1;
        if (b == 1) minus_btn_o <= 1'b1;
        if (b == 2) plus_btn_o <= 1'b1;
        repeat (8) @(posedge mclk_i);
        {mode_btn_o, minus_btn_o, plus_btn_o} <= 3'b000;
        repeat (14) @(posedge mclk_i);
    endtask
    task automatic hold(input logic mn, input logic pl);
        @(posedge mclk_i);
        minus_btn_o <= mn;
        plus_btn_o  <= pl;
    endtask
    task automatic enable_ft(input logic on);
        @(posedge mclk_i);
        ft_enable_o <= on;
    endtask
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the panel clock modes, setting, timers and test mode.
// Assumes: Shortened counts: 20-cycle second, 3-cycle debounce, 40-cycle test hold.
// Notes:   Mode is modelled as an integer, annunciators derived from it.
`timescale 1ns/1ps
module testbench;
    import clock_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, main_power_i = 1'b1;
    logic set_i = 1'b0, set_utc_i = 1'b0, set_mmss_i = 1'b0, ft_clear_i = 1'b0;
    logic [4:0] set_hh_i = 5'h00;
    logic [5:0] set_mm_i = 6'h00, set_ss_i = 6'h00;
    logic mode_b, minus_b, plus_b, ft_en, dp_o, ann_utc_o, ann_flight_o, ann_timer_o;
    logic hour24 = 1'b1, show_sec = 1'b1;
    logic [23:0] digits_o, snap;
    int fails = 0, check_count = 0, mode = 0, cyc = 0, mm, mm2, hh, sec, h12, dp_cnt;

    panel_model pnl (.mclk_i(mclk_i), .mode_btn_o(mode_b), .minus_btn_o(minus_b),
        .plus_btn_o(plus_b), .ft_enable_o(ft_en));
    cockpit_clock_chronometer #(.SEC_CYC(20), .BLINK_CYC(4), .TEST_CYC(40), .DEB_CYC(3)) dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .main_power_i(main_power_i), .mode_btn_i(mode_b),
        .minus_btn_i(minus_b), .plus_btn_i(plus_b), .ft_enable_i(ft_en), .hour24_i(hour24),
        .show_sec_i(show_sec), .set_i(set_i), .set_utc_i(set_utc_i), .set_mmss_i(set_mmss_i),
        .set_hh_i(set_hh_i), .set_mm_i(set_mm_i), .set_ss_i(set_ss_i), .ft_clear_i(ft_clear_i),
        .digits_o(digits_o), .dp_o(dp_o), .ann_utc_o(ann_utc_o), .ann_flight_o(ann_flight_o),
        .ann_timer_o(ann_timer_o));

    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // ==========================================================
    // Checking helpers
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] bcd(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction
    task automatic chk_ann();
        chk({21'h0, ann_utc_o, ann_flight_o, ann_timer_o},
            {21'h0, mode == 1, mode == 2, mode == 3});
    endtask
    task automatic step_mode();
        pnl.press(0);
        mode = (mode + 1) % 4;
    endtask
    task automatic load(input logic utc, input int h, input int m, input logic mmss,
                        input int s);
        @(posedge mclk_i);
        {set_i, set_utc_i, set_mmss_i} <= {1'b1, utc, mmss};
        set_hh_i <= 5'(h);
        set_mm_i <= 6'(m);
        set_ss_i <= 6'(s);
        @(posedge mclk_i);
        set_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            test_done();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(24239));
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (20) @(negedge mclk_i);
        chk_ann();
        mm = $urandom % 60;
        hh = $urandom % 24;
        sec = $urandom % 50;
        load(1'b0, hh, mm, 1'b1, sec);
        @(negedge mclk_i);
        chk(digits_o[23:8], {8'h00, bcd(hh), bcd(mm)});
        h12 = (hh % 12 == 0) ? 12 : hh % 12;
        @(posedge mclk_i) {hour24, show_sec} <= 2'b00;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, {8'hff, bcd(h12), bcd(mm)});
        @(posedge mclk_i) {hour24, show_sec} <= 2'b11;
        // Hours only: the shared minutes must stay put
        load(1'b0, hh, 59, 1'b0, 59);
        @(negedge mclk_i);
        chk(digits_o[15:8], bcd(mm));
        step_mode();
        @(negedge mclk_i);
        chk_ann();
        chk(digits_o[15:8], bcd(mm));
        $display("setting and universal mode done");
        mm2 = (mm + 1 + $urandom % 58) % 60;
        load(1'b1, 5, mm2, 1'b1, $urandom % 50);
        @(posedge mclk_i) main_power_i <= 1'b0;
        repeat (14) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, ALL_BLANK);
        chk({21'h0, ann_utc_o, ann_flight_o, ann_timer_o}, 24'h0);
        @(posedge mclk_i) main_power_i <= 1'b1;
        repeat (14) @(posedge mclk_i);
        @(negedge mclk_i);
        mode = 0;
        chk_ann();
        chk(digits_o[15:8], bcd(mm2));
        $display("power cycle done");
        repeat (3) begin
            step_mode();
            @(negedge mclk_i);
            chk_ann();
        end
        pnl.press(2);
        repeat (50) @(posedge mclk_i);
        pnl.press(1);
        @(negedge mclk_i);
        chk(digits_o[23:8], 24'h0);
        repeat (60) @(posedge mclk_i);
        @(negedge mclk_i);
        chk({23'h0, digits_o[7:0] != 8'h00}, 24'h1);
        pnl.press(2);
        @(negedge mclk_i);
        snap = digits_o;
        repeat (60) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, snap);
        step_mode();
        @(negedge mclk_i);
        chk_ann();
        $display("mode cycle and elapsed timer done");
        pnl.hold(1'b1, 1'b1);
        repeat (60) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, ALL_EIGHT);
        chk({20'h0, dp_o, ann_utc_o, ann_flight_o, ann_timer_o}, 24'hf);
        pnl.hold(1'b0, 1'b0);
        repeat (14) @(posedge mclk_i);
        @(negedge mclk_i);
        chk_ann();
        $display("display test done");
        repeat (2) step_mode();
        @(negedge mclk_i);
        chk_ann();
        chk(digits_o, 24'h0);
        // Any 40-cycle window (two shortened seconds) holds one 4-cycle blink
        dp_cnt = 0;
        repeat (40) begin
            @(negedge mclk_i);
            dp_cnt += dp_o;
        end
        chk(24'(dp_cnt), 24'h4);
        // 360 counted seconds make one tenth; by now between 360 and 719 have passed
        repeat (7400) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, 24'h1);
        @(posedge mclk_i) ft_clear_i <= 1'b1;
        @(posedge mclk_i) ft_clear_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, 24'h0);
        pnl.hold(1'b0, 1'b1);
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(digits_o, 24'h1);
        pnl.hold(1'b0, 1'b0);
        pnl.enable_ft(1'b0);
        repeat (12) @(posedge mclk_i);
        dp_cnt = 0;
        repeat (40) begin
            @(negedge mclk_i);
            dp_cnt += dp_o;
        end
        chk(24'(dp_cnt), 24'h0);
        chk(digits_o, 24'h0);
        $display("flight timer done");
        test_done();
    end
endmodule
